// ===== hw/smbus_rom_pkg.sv
// Shared constants and types for the two-wire information ROM link.
// Assumes both ends run on one 25 MHz clock with a synchronous reset.
package smbus_rom_pkg;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 40; // System clock period
	localparam int SCL_PERIOD_NS = 10000; // Link clock period, 100 kHz
	// Quarter of a link clock period, rounded down
	localparam logic [6:0] SCL_QUARTER_CYC =
		7'(SCL_PERIOD_NS / (4 * CLK_PERIOD_NS));

	// ------------------------------------------------------------
	// Target addresses (chosen, not identity codes)
	// ------------------------------------------------------------
	localparam logic [6:0] ROM_DEV_ADDR = 7'h50; // Information ROM
	localparam logic [6:0] EE_DEV_ADDR = 7'h54; // Scratch storage

	// ------------------------------------------------------------
	// Information ROM layout
	// ------------------------------------------------------------
	localparam logic [6:0] PTR_THERMAL_OFS = 7'h08; // Pointer bytes
	localparam logic [6:0] PTR_FEATURE_OFS = 7'h09;
	localparam logic [6:0] THERMAL_REF_OFS = 7'h70; // thermal_reference_byte
	localparam logic [6:0] THERMAL_CSUM_OFS = 7'h73;
	localparam logic [6:0] CORE_FLAGS_OFS = 7'h74; // core_feature_flags
	localparam logic [6:0] CART_FLAGS_OFS = 7'h78; // cartridge_presence_flags
	localparam logic [6:0] TAP_COUNT_OFS = 7'h7C; // test_chain_device_count
	localparam logic [6:0] FEATURE_CSUM_OFS = 7'h7D;
	localparam logic [6:0] RESERVED_TAIL_OFS = 7'h7E; // Reads zero

	// Cartridge presence flag bit positions
	localparam int FLAG_SERIAL_SIG = 6;
	localparam int FLAG_ELEC_SIG = 5;
	localparam int FLAG_THERMAL_DEV = 4;
	localparam int FLAG_THERMAL_REF = 3;
	localparam int FLAG_SPARE_STORE = 2;
	localparam int FLAG_CORE_VID = 1;
	localparam int FLAG_CACHE_VID = 0;

	// Storage geometry
	localparam int STORE_BYTES = 128; // 1024 bits
	localparam int PAGE_BYTES = 8;

	// ------------------------------------------------------------
	// Host command codes
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		OP_CUR_READ = 2'h0,
		OP_RAND_READ = 2'h1,
		OP_WRITE = 2'h2
	} op_type;

	// Byte being received by the target
	typedef enum logic [1:0] {
		K_ADDR = 2'h0,
		K_LOC = 2'h1,
		K_DATA = 2'h2
	} kind_type;

	// Target states, one-hot
	typedef enum logic [4:0] {
		D_IDLE = 5'h01,
		D_RX = 5'h02,
		D_ACK = 5'h04,
		D_TX = 5'h08,
		D_RACK = 5'h10
	} dstate_type;

	// Host states, one-hot
	typedef enum logic [3:0] {
		H_IDLE = 4'h1,
		H_START = 4'h2,
		H_BYTE = 4'h4,
		H_STOP = 4'h8
	} hstate_type;

endpackage : smbus_rom_pkg

// ===== hw/smbus_link_if.sv
// Two-wire link between the host end and the target end.
// Assumes open-drain wires with pull-ups; an enable low means released.
`timescale 1ns/1ps
`default_nettype none
interface smbus_link_if;
	// ------------------------------------------------------------
	// Pin drivers
	// ------------------------------------------------------------
	logic host_scl_o; // Host clock value when driven
	logic host_scl_oe; // Host pulls clock
	logic host_sda_o; // Host data value when driven
	logic host_sda_oe; // Host pulls data
	logic dev_sda_o; // Target data value when driven
	logic dev_sda_oe; // Target pulls data
	logic scl; // Resolved clock wire
	logic sda; // Resolved data wire

	// Wired-AND with pull-up
	assign scl = host_scl_oe ? host_scl_o : 1'b1;
	assign sda = (host_sda_oe ? host_sda_o : 1'b1) &
		(dev_sda_oe ? dev_sda_o : 1'b1);

	modport host (
		output host_scl_o, host_scl_oe, host_sda_o, host_sda_oe,
		input scl, sda
	);
	modport dev (
		output dev_sda_o, dev_sda_oe,
		input scl, sda
	);
endinterface : smbus_link_if
`default_nettype wire

// ===== hw/smbus_rom_target.sv
// Target end: information ROM and scratch storage behind one link.
// Assumes the host makes the link clock; both wires are resynchronised.
//
// How it works
// - ROM serves current, random, sequential reads
// - Scratch storage adds byte and page writes
// - Counter holds last location plus one
// - Reads wrap from last byte to zero
// - Writes wrap inside the current page
// - Random read loads counter from location byte
// - Sequential read continues while host acknowledges
// - Current read: ack address, send one byte
// - Byte write acks address, location and data
// - Page write advances address per byte
// - Storage acknowledges every written data byte
// - Over eight bytes overwrite earlier page bytes
// - Top bit of location byte ignored
// - Write-protect high blocks storage programming
// - Storage holds 1024 bits as bytes
// - Presence flags at bits six down zero
// - Feature section order: core, flags, count, sum
// - Pointer bytes hold section location or zero
`timescale 1ns/1ps
`default_nettype none
module smbus_rom_target #(
	parameter logic [7:0] THERMAL_REF = 8'h40, // Per-unit reference
	parameter logic [31:0] CORE_FLAGS = 32'h0000_0000, // Copied core word
	parameter logic [6:0] OTHER_FLAGS = 7'h00, // Bits 6,5,4,1,0 used
	parameter logic [3:0] TAP_COUNT = 4'h1 // Devices on test chain
) (
	// Clock and reset
	input wire logic clk_in,
	input wire logic rst_n_in,
	// Link
	smbus_link_if.dev link,
	// User side
	input wire logic wp_in,
	output logic [6:0] ptr_out,
	output logic busy_out
);
	import smbus_rom_pkg::*;

	// ------------------------------------------------------------
	// ROM contents
	// ------------------------------------------------------------
	// Presence word: thermal reference and spare storage always fitted
	localparam logic [31:0] CART_FLAGS = {25'h0,
		OTHER_FLAGS & 7'h73} | (32'h1 << FLAG_THERMAL_REF) |
		(32'h1 << FLAG_SPARE_STORE);
	// Feature section bytes, low byte of each word first
	localparam logic [7:0] TAP_BYTE = {4'h0, TAP_COUNT};
	localparam logic [7:0] FEAT_SUM = 8'(CORE_FLAGS[7:0] +
		CORE_FLAGS[15:8] + CORE_FLAGS[23:16] + CORE_FLAGS[31:24] +
		CART_FLAGS[7:0] + CART_FLAGS[15:8] + CART_FLAGS[23:16] +
		CART_FLAGS[31:24] + TAP_BYTE);

	// Fixed image; unlisted locations read zero
	function automatic logic [7:0] rom_byte(input logic [6:0] a);
		logic [31:0] word;
		word = (a < CART_FLAGS_OFS) ? CORE_FLAGS : CART_FLAGS;
		rom_byte = 8'h00;
		if (a == PTR_THERMAL_OFS) begin
			rom_byte = {1'b0, THERMAL_REF_OFS};
		end else if (a == PTR_FEATURE_OFS) begin
			rom_byte = {1'b0, CORE_FLAGS_OFS};
		end else if (a == THERMAL_REF_OFS) begin
			rom_byte = THERMAL_REF;
		end else if (a == THERMAL_CSUM_OFS) begin
			rom_byte = 8'(8'h00 - THERMAL_REF);
		end else if (a >= CORE_FLAGS_OFS && a < TAP_COUNT_OFS) begin
			rom_byte = word[8 * a[1:0] +: 8];
		end else if (a == TAP_COUNT_OFS) begin
			rom_byte = TAP_BYTE;
		end else if (a == FEATURE_CSUM_OFS) begin
			rom_byte = 8'(8'h00 - FEAT_SUM);
		end
	endfunction : rom_byte

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	typedef struct packed {
		logic [STORE_BYTES-1:0][7:0] mem; // Scratch storage
		logic [6:0] ptr; // Address counter
		dstate_type st; // Protocol state
		kind_type kind; // Meaning of the byte in flight
		logic [7:0] sh; // Shift register
		logic [3:0] cnt; // Bit counter
		logic sel_ee; // Storage, not ROM, addressed
		logic rd; // Read direction
		logic hack; // Host acknowledged last byte
		logic sda_o; // Pin value when driven
		logic sda_oe; // Pin pulled low
		logic scl_s1; // Clock synchroniser
		logic scl_s2;
		logic scl_p; // Previous synchronised clock
		logic sda_s1; // Data synchroniser
		logic sda_s2;
		logic sda_p; // Previous synchronised data
		logic wp_s1; // Write-protect synchroniser
		logic wp_s2;
		logic busy; // Transfer in progress
	} dev_state_type;

	dev_state_type s_r; // Registered state
	dev_state_type s_nxt; // Next state
	logic rise; // Link clock rising edge
	logic fall; // Link clock falling edge
	logic start_seen; // Start or repeated start
	logic stop_seen; // Stop
	logic [7:0] rd_byte; // Byte at the counter

	// ------------------------------------------------------------
	// Line events
	// ------------------------------------------------------------
	// Edges only look at the second stage, never the first
	assign rise = s_r.scl_s2 & ~s_r.scl_p;
	assign fall = ~s_r.scl_s2 & s_r.scl_p;
	assign start_seen = s_r.scl_s2 & s_r.scl_p & s_r.sda_p & ~s_r.sda_s2;
	assign stop_seen = s_r.scl_s2 & s_r.scl_p & ~s_r.sda_p & s_r.sda_s2;
	// Read source follows the addressed target
	assign rd_byte = s_r.sel_ee ? s_r.mem[s_r.ptr] : rom_byte(s_r.ptr);

	// ------------------------------------------------------------
	// Next-state logic
	// ------------------------------------------------------------
	always_comb begin
		s_nxt = s_r;
		// Synchronisers
		s_nxt.scl_s1 = link.scl;
		s_nxt.scl_s2 = s_r.scl_s1;
		s_nxt.scl_p = s_r.scl_s2;
		s_nxt.sda_s1 = link.sda;
		s_nxt.sda_s2 = s_r.sda_s1;
		s_nxt.sda_p = s_r.sda_s2;
		s_nxt.wp_s1 = wp_in;
		s_nxt.wp_s2 = s_r.wp_s1;
		if (stop_seen) begin
			// Stop ends any transfer
			s_nxt.st = D_IDLE;
			s_nxt.sda_oe = 1'b0;
		end else if (start_seen) begin
			// Start or repeated start: expect an address byte
			s_nxt.st = D_RX;
			s_nxt.kind = K_ADDR;
			s_nxt.cnt = 4'h0;
			s_nxt.sda_oe = 1'b0;
		end else begin
			case (s_r.st)
				D_IDLE: begin
					s_nxt.sda_oe = 1'b0;
				end
				D_RX: begin
					// Sample on rise, decide on the eighth fall
					if (rise && s_r.cnt != 4'h8) begin
						s_nxt.sh = {s_r.sh[6:0], s_r.sda_s2};
						s_nxt.cnt = s_r.cnt + 4'h1;
					end else if (fall && s_r.cnt == 4'h8) begin
						s_nxt.st = D_ACK;
						s_nxt.sda_oe = 1'b1;
						case (s_r.kind)
							K_ADDR: begin
								if (s_r.sh[7:1] == ROM_DEV_ADDR) begin
									s_nxt.sel_ee = 1'b0;
									s_nxt.rd = s_r.sh[0];
									s_nxt.kind = K_LOC;
								end else if (s_r.sh[7:1] == EE_DEV_ADDR) begin
									s_nxt.sel_ee = 1'b1;
									s_nxt.rd = s_r.sh[0];
									s_nxt.kind = K_LOC;
								end else begin
									// Not ours: stay off the line
									s_nxt.st = D_IDLE;
									s_nxt.sda_oe = 1'b0;
								end
							end
							K_LOC: begin
								// Top bit is a don't care
								s_nxt.ptr = s_r.sh[6:0];
								s_nxt.kind = K_DATA;
							end
							K_DATA: begin
								if (s_r.sel_ee) begin
									// Ack even when protected
									if (!s_r.wp_s2) begin
										s_nxt.mem[s_r.ptr] = s_r.sh;
									end
									// Stay inside the page
									s_nxt.ptr = {s_r.ptr[6:3],
										s_r.ptr[2:0] + 3'h1};
								end else begin
									// ROM refuses data bytes
									s_nxt.st = D_IDLE;
									s_nxt.sda_oe = 1'b0;
								end
							end
							default: begin
								s_nxt.st = D_IDLE;
								s_nxt.sda_oe = 1'b0;
							end
						endcase
					end
				end
				D_ACK: begin
					// Release ack; reads put the first bit out at once
					if (fall) begin
						s_nxt.cnt = 4'h0;
						if (s_r.rd) begin
							s_nxt.sh = rd_byte;
							s_nxt.sda_oe = ~rd_byte[7];
							s_nxt.st = D_TX;
						end else begin
							s_nxt.sda_oe = 1'b0;
							s_nxt.st = D_RX;
						end
					end
				end
				D_TX: begin
					// Shift out on each fall, release after bit zero
					if (fall) begin
						if (s_r.cnt == 4'h7) begin
							s_nxt.sda_oe = 1'b0;
							s_nxt.st = D_RACK;
						end else begin
							s_nxt.sh = {s_r.sh[6:0], 1'b0};
							s_nxt.sda_oe = ~s_r.sh[6];
							s_nxt.cnt = s_r.cnt + 4'h1;
						end
					end
				end
				D_RACK: begin
					// Counter steps past the byte just sent
					if (rise) begin
						s_nxt.hack = ~s_r.sda_s2;
						s_nxt.ptr = s_r.ptr + 7'h01;
					end else if (fall) begin
						if (s_r.hack) begin
							s_nxt.sh = rd_byte;
							s_nxt.sda_oe = ~rd_byte[7];
							s_nxt.cnt = 4'h0;
							s_nxt.st = D_TX;
						end else begin
							// Not-acknowledge: wait for stop
							s_nxt.st = D_IDLE;
						end
					end
				end
				default: begin
					s_nxt.st = D_IDLE;
					s_nxt.sda_oe = 1'b0;
				end
			endcase
		end
		// Busy kept as its own flop so the output is a plain register
		s_nxt.busy = (s_nxt.st != D_IDLE);
	end

	// ------------------------------------------------------------
	// State register
	// ------------------------------------------------------------
	// Storage is cleared by reset; a real part keeps it across power
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			s_r <= '0;
			s_r.st <= D_IDLE;
			s_r.scl_s1 <= 1'b1;
			s_r.scl_s2 <= 1'b1;
			s_r.scl_p <= 1'b1;
			s_r.sda_s1 <= 1'b1;
			s_r.sda_s2 <= 1'b1;
			s_r.sda_p <= 1'b1;
		end else begin
			s_r <= s_nxt;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign link.dev_sda_o = s_r.sda_o;
	assign link.dev_sda_oe = s_r.sda_oe;
	assign ptr_out = s_r.ptr;
	assign busy_out = s_r.busy;

endmodule : smbus_rom_target
`default_nettype wire

// ===== hw/smbus_rom_host.sv
// Host end: issues reads and writes to the ROM or scratch storage.
// Assumes one command at a time, taken while busy_out is low.
`timescale 1ns/1ps
`default_nettype none
module smbus_rom_host (
	// Clock and reset
	input wire logic clk_in,
	input wire logic rst_n_in,
	// Link
	smbus_link_if.host link,
	// Command
	input wire logic cmd_valid_in,
	input wire smbus_rom_pkg::op_type op_in,
	input wire logic ee_sel_in,
	input wire logic [7:0] loc_in,
	input wire logic [3:0] count_in,
	// Write data
	input wire logic [7:0] wr_data_in,
	output logic wr_take_out,
	// Results
	output logic [7:0] rd_data_out,
	output logic rd_valid_out,
	output logic done_out,
	output logic nack_out,
	output logic busy_out
);
	import smbus_rom_pkg::*;

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	typedef struct packed {
		hstate_type st; // Sequencer state
		logic [6:0] q; // Quarter-period counter
		logic [1:0] ph; // Quarter within a bit
		logic [3:0] bitn; // Bit within a byte, 8 is ack
		logic [7:0] sh; // Shift register
		logic tx; // Host sends this byte
		logic [1:0] seg; // 0 addr, 1 loc, 2 read addr, 3 data
		logic ackbit; // Sampled ack, high is refusal
		op_type op; // Latched command
		logic ee; // Latched target
		logic [7:0] loc; // Latched location
		logic [3:0] left; // Data bytes still to go
		logic scl_o; // Pin values when driven
		logic sda_o;
		logic scl_oe; // Host pulls clock
		logic sda_oe; // Host pulls data
		logic sda_s1; // Data synchroniser
		logic sda_s2;
		logic [7:0] rd_data; // Last received byte
		logic rd_valid; // Pulse
		logic wr_take; // Pulse
		logic done; // Pulse
		logic nack; // Level until next command
		logic busy; // Command in progress
	} host_state_type;

	host_state_type s_r; // Registered state
	host_state_type s_nxt; // Next state
	logic tick; // End of a quarter
	logic [1:0] nph; // Quarter being entered
	logic [6:0] dev_addr; // Target address

	assign tick = (s_r.q == SCL_QUARTER_CYC - 7'h01);
	assign nph = s_r.ph + 2'h1;
	assign dev_addr = s_r.ee ? EE_DEV_ADDR : ROM_DEV_ADDR;

	// ------------------------------------------------------------
	// Next-state logic
	// ------------------------------------------------------------
	always_comb begin
		s_nxt = s_r;
		s_nxt.sda_s1 = link.sda;
		s_nxt.sda_s2 = s_r.sda_s1;
		s_nxt.rd_valid = 1'b0;
		s_nxt.wr_take = 1'b0;
		s_nxt.done = 1'b0;
		s_nxt.q = tick ? 7'h00 : s_r.q + 7'h01;
		if (tick) begin
			s_nxt.ph = nph;
		end
		case (s_r.st)
			H_IDLE: begin
				// Take a command, line stays released
				s_nxt.q = 7'h00;
				s_nxt.ph = 2'h0;
				if (cmd_valid_in) begin
					s_nxt.op = op_in;
					s_nxt.ee = ee_sel_in;
					s_nxt.loc = loc_in;
					s_nxt.left = count_in;
					s_nxt.seg = 2'h0;
					s_nxt.nack = 1'b0;
					s_nxt.busy = 1'b1;
					s_nxt.st = H_START;
				end
			end
			H_START: begin
				// Release, raise clock, pull data, lower clock
				if (tick) begin
					case (nph)
						2'h1: s_nxt.scl_oe = 1'b0;
						2'h2: s_nxt.sda_oe = 1'b1;
						2'h3: s_nxt.scl_oe = 1'b1;
						default: begin
							s_nxt.st = H_BYTE;
							s_nxt.bitn = 4'h0;
							s_nxt.tx = 1'b1;
							// Read bit set for current read or second address
							s_nxt.sh = {dev_addr, (s_r.seg == 2'h2) ||
								(s_r.op == OP_CUR_READ)};
							s_nxt.sda_oe = ~s_nxt.sh[7];
						end
					endcase
				end else if (s_r.ph == 2'h0) begin
					s_nxt.sda_oe = 1'b0;
				end
			end
			H_BYTE: begin
				if (tick) begin
					case (nph)
						2'h1: s_nxt.scl_oe = 1'b0;
						2'h2: begin
							// Sample mid-high
							if (s_r.bitn == 4'h8) begin
								s_nxt.ackbit = s_r.sda_s2;
							end else if (!s_r.tx) begin
								s_nxt.sh = {s_r.sh[6:0], s_r.sda_s2};
							end
						end
						2'h3: s_nxt.scl_oe = 1'b1;
						default: begin
							if (s_r.bitn != 4'h8) begin
								s_nxt.bitn = s_r.bitn + 4'h1;
								if (s_r.bitn == 4'h7) begin
									// Ack slot: ack all but the last byte
									s_nxt.sda_oe = ~s_r.tx &&
										(s_r.left != 4'h1);
									s_nxt.rd_data = s_r.sh;
									s_nxt.rd_valid = ~s_r.tx;
								end else begin
									// Received bits shift in at the sample point only
									if (s_r.tx) begin
										s_nxt.sh = {s_r.sh[6:0], 1'b0};
									end
									s_nxt.sda_oe = s_r.tx & ~s_r.sh[6];
								end
							end else if (s_r.tx && s_r.ackbit) begin
								// Refused: abandon with stop
								s_nxt.nack = 1'b1;
								s_nxt.st = H_STOP;
								s_nxt.sda_oe = 1'b1;
							end else begin
								s_nxt.bitn = 4'h0;
								s_nxt.tx = 1'b0;
								s_nxt.sda_oe = 1'b0;
								case (s_r.seg)
									2'h0: begin
										if (s_r.op != OP_CUR_READ) begin
											// Full 8-bit location
											s_nxt.seg = 2'h1;
											s_nxt.tx = 1'b1;
											s_nxt.sh = s_r.loc;
											s_nxt.sda_oe = ~s_r.loc[7];
										end else begin
											s_nxt.seg = 2'h3;
										end
									end
									2'h1: begin
										if (s_r.op == OP_RAND_READ) begin
											// Repeated start, no data
											s_nxt.seg = 2'h2;
											s_nxt.st = H_START;
										end else begin
											s_nxt.seg = 2'h3;
											s_nxt.tx = 1'b1;
											s_nxt.sh = wr_data_in;
											s_nxt.sda_oe = ~wr_data_in[7];
											s_nxt.wr_take = 1'b1;
										end
									end
									2'h2: s_nxt.seg = 2'h3;
									default: begin
										s_nxt.left = s_r.left - 4'h1;
										if (s_r.left == 4'h1) begin
											s_nxt.st = H_STOP;
											s_nxt.sda_oe = 1'b1;
										end else if (s_r.op == OP_WRITE) begin
											// Page write: no stop yet
											s_nxt.tx = 1'b1;
											s_nxt.sh = wr_data_in;
											s_nxt.sda_oe = ~wr_data_in[7];
											s_nxt.wr_take = 1'b1;
										end
									end
								endcase
							end
						end
					endcase
				end
			end
			H_STOP: begin
				// Data low, raise clock, release data
				if (tick) begin
					case (nph)
						2'h1: s_nxt.scl_oe = 1'b0;
						2'h2: s_nxt.sda_oe = 1'b0;
						2'h3: s_nxt.sda_oe = 1'b0;
						default: begin
							s_nxt.st = H_IDLE;
							s_nxt.done = 1'b1;
							s_nxt.busy = 1'b0;
						end
					endcase
				end
			end
			default: s_nxt.st = H_IDLE;
		endcase
	end

	// ------------------------------------------------------------
	// State register
	// ------------------------------------------------------------
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			s_r <= '0;
			s_r.st <= H_IDLE;
			s_r.sda_s1 <= 1'b1;
			s_r.sda_s2 <= 1'b1;
		end else begin
			s_r <= s_nxt;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign link.host_scl_o = s_r.scl_o;
	assign link.host_scl_oe = s_r.scl_oe;
	assign link.host_sda_o = s_r.sda_o;
	assign link.host_sda_oe = s_r.sda_oe;
	assign wr_take_out = s_r.wr_take;
	assign rd_data_out = s_r.rd_data;
	assign rd_valid_out = s_r.rd_valid;
	assign done_out = s_r.done;
	assign nack_out = s_r.nack;
	assign busy_out = s_r.busy;

endmodule : smbus_rom_host
`default_nettype wire

// ===== tb/smbus_link_asserts.sv
// Checker for the two-wire link joining host and target ends.
// Assumes the bench wires it beside the link interface instance.
`timescale 1ns/1ps
`default_nettype none
module smbus_link_asserts (
	// Clock and reset
	input wire logic clk_in,
	input wire logic rst_n_in,
	// Link signals
	input wire logic host_scl_o,
	input wire logic host_scl_oe,
	input wire logic host_sda_o,
	input wire logic host_sda_oe,
	input wire logic dev_sda_o,
	input wire logic dev_sda_oe,
	input wire logic scl,
	input wire logic sda
);
	// ------------------------------------------------------------
	// Properties
	// ------------------------------------------------------------
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);
	// Start and stop conditions, seen only while clock is high
	sequence s_start;
		scl && $fell(sda);
	endsequence
	sequence s_stop;
		scl && $rose(sda);
	endsequence
	// Open-drain: drivers only ever pull low
	property p_scl_od;
		host_scl_o == 1'b0;
	endproperty
	property p_sda_od;
		host_sda_o == 1'b0 && dev_sda_o == 1'b0;
	endproperty
	// Released clock wire floats high
	property p_scl_wire;
		!host_scl_oe |-> scl;
	endproperty
	// Target has let go of data when the host ends with a stop
	property p_sda_wire;
		scl && $fell(host_sda_oe) |-> !dev_sda_oe;
	endproperty
	// Target moves data only while the clock is low
	property p_dev_edge;
		$changed(dev_sda_oe) |-> !scl;
	endproperty
	// Clock phases last half a period, never a few cycles
	property p_scl_stand;
		$changed(host_scl_oe) |=> $stable(host_scl_oe) [*8];
	endproperty
	// Clock falls one quarter after a start
	property p_start;
		s_start |-> ##[50:70] !scl;
	endproperty
	// After a stop the link rests idle
	property p_stop;
		s_stop |-> (scl && !host_sda_oe) [*8];
	endproperty
	a_scl_od: assert property (p_scl_od) else $error("clock driven high");
	a_sda_od: assert property (p_sda_od) else $error("data driven high");
	a_scl_wire: assert property (p_scl_wire) else $error("clock not idle high");
	a_sda_wire: assert property (p_sda_wire) else $error("target holds data at stop");
	a_dev_edge: assert property (p_dev_edge) else $error("target data moved");
	a_scl_stand: assert property (p_scl_stand) else $error("clock glitch");
	a_start: assert property (p_start) else $error("no clock after start");
	a_stop: assert property (p_stop) else $error("link busy after stop");
endmodule : smbus_link_asserts
`default_nettype wire

// ===== tb/smbus_info_rom_scratch_eeprom_tb_top.sv
// Bench driving the host end against the target end over one link.
// Assumes the package, interface, both ends and checker compile first.
`timescale 1ns/1ps
`default_nettype none
module smbus_info_rom_scratch_eeprom_tb_top;
	import smbus_rom_pkg::*;
	// ------------------------------------------------------------
	// Signals
	// ------------------------------------------------------------
	logic clk_in = 1'b0; // 25 MHz
	logic rst_n_in = 1'b0;
	logic wp_in = 1'b0;
	logic cmd_valid_in = 1'b0;
	op_type op_in = OP_WRITE;
	logic ee_sel_in = 1'b0;
	logic [7:0] loc_in = 8'h00;
	logic [3:0] count_in = 4'h1;
	logic [7:0] wr_data_in = 8'h00;
	logic wr_take_out, rd_valid_out, done_out, nack_out, busy_out, dev_busy;
	logic [7:0] rd_data_out;
	logic [6:0] ptr_out;
	logic [7:0] wd [0:15]; // Bytes to send, in order
	logic [7:0] rxq [$]; // Bytes read back
	int errors = 0;
	int compares = 0;
	smbus_link_if link ();
	smbus_rom_target #(.OTHER_FLAGS(7'h53), .TAP_COUNT(4'h3))
		smbus_rom_target_i (.clk_in(clk_in), .rst_n_in(rst_n_in),
		.link(link.dev), .wp_in(wp_in), .ptr_out(ptr_out),
		.busy_out(dev_busy));
	smbus_rom_host smbus_rom_host_i (.clk_in(clk_in), .rst_n_in(rst_n_in),
		.link(link.host), .cmd_valid_in(cmd_valid_in), .op_in(op_in),
		.ee_sel_in(ee_sel_in), .loc_in(loc_in), .count_in(count_in),
		.wr_data_in(wr_data_in), .wr_take_out(wr_take_out),
		.rd_data_out(rd_data_out), .rd_valid_out(rd_valid_out),
		.done_out(done_out), .nack_out(nack_out), .busy_out(busy_out));
	smbus_link_asserts smbus_link_asserts_i (.clk_in(clk_in),
		.rst_n_in(rst_n_in), .host_scl_o(link.host_scl_o),
		.host_scl_oe(link.host_scl_oe), .host_sda_o(link.host_sda_o),
		.host_sda_oe(link.host_sda_oe), .dev_sda_o(link.dev_sda_o),
		.dev_sda_oe(link.dev_sda_oe), .scl(link.scl), .sda(link.sda));
	// 40 ns period
	initial begin
		forever #20 clk_in = ~clk_in;
	end
	// ------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------
	task automatic chk(input string what, input logic [7:0] seen, exp);
		compares++;
		if (seen !== exp) begin
			errors++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	task automatic wrap_up();
		$display("compares %0d errors %0d", compares, errors);
		if (errors == 0 && compares > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : wrap_up
	// One command; request held until the host shows busy
	task automatic run(input op_type op, input logic ee,
		input logic [7:0] loc, input logic [3:0] n);
		int i;
		int k;
		i = 0;
		k = 0;
		rxq.delete();
		@(negedge clk_in);
		op_in = op;
		ee_sel_in = ee;
		loc_in = loc;
		count_in = n;
		wr_data_in = wd[0];
		cmd_valid_in = 1'b1;
		while (done_out !== 1'b1 && i < 60000) begin
			@(negedge clk_in);
			if (busy_out === 1'b1) begin
				cmd_valid_in = 1'b0;
			end
			if (rd_valid_out === 1'b1) begin
				rxq.push_back(rd_data_out);
			end
			if (wr_take_out === 1'b1) begin
				k++;
				wr_data_in = wd[k[3:0]];
			end
			i++;
		end
		if (i >= 60000) begin
			errors++;
			wrap_up();
		end
	endtask : run
	// Read command compared byte by byte
	task automatic rd(input op_type op, input logic ee,
		input logic [7:0] loc, input logic [7:0] e []);
		run(op, ee, loc, 4'(e.size()));
		chk("read count", 8'(rxq.size()), 8'(e.size()));
		foreach (e[j]) begin
			chk("read byte", rxq[j], e[j]);
		end
	endtask : rd
	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		for (int j = 0; j < 16; j++) begin
			wd[j] = 8'hD0 + 8'(j);
		end
		repeat (12) @(negedge clk_in);
		rst_n_in = 1'b1;
		// Nine bytes from location 5 wrap and overwrite
		run(OP_WRITE, 1'b1, 8'h85, 4'h9);
		chk("nack", {7'h00, nack_out}, 8'h00);
		chk("ptr", {1'b0, ptr_out}, 8'h06);
		// Protected write still acked, nothing stored
		wd[0] = 8'h5A;
		wp_in = 1'b1;
		run(OP_WRITE, 1'b1, 8'h7F, 4'h1);
		wp_in = 1'b0;
		chk("nack", {7'h00, nack_out}, 8'h00);
		chk("ptr", {1'b0, ptr_out}, 8'h78);
		rd(OP_RAND_READ, 1'b1, 8'h7F, '{8'h00, 8'hD3, 8'hD4, 8'hD5,
			8'hD6, 8'hD7, 8'hD8, 8'hD1});
		chk("ptr", {1'b0, ptr_out}, 8'h07);
		rd(OP_CUR_READ, 1'b1, 8'h00, '{8'hD2});
		// Feature section: flags, count, checksum
		rd(OP_RAND_READ, 1'b0, 8'h78, '{8'h5F, 8'h00, 8'h00, 8'h00,
			8'h03, 8'h9E});
		// ROM data byte is refused; only the counter moves
		run(OP_WRITE, 1'b0, 8'h08, 4'h1);
		chk("nack", {7'h00, nack_out}, 8'h01);
		chk("ptr", {1'b0, ptr_out}, 8'h08);
		chk("target idle", {7'h00, dev_busy}, 8'h00);
		// Pointer bytes of the thermal and feature sections
		rd(OP_CUR_READ, 1'b0, 8'h00, '{8'h70, 8'h74});
		wrap_up();
	end
endmodule : smbus_info_rom_scratch_eeprom_tb_top
`default_nettype wire
